// ### pkg/sec_defs.vh
`ifndef SEC_DEFS_VH
`define SEC_DEFS_VH

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define SEC_OP_SET_WEL    8'h06
`define SEC_OP_CLR_WEL    8'h04
`define SEC_OP_RD_STATUS  8'h05
`define SEC_OP_WR_STATUS  8'h01
`define SEC_OP_RD_MEM     8'h03
`define SEC_OP_WR_MEM     8'h02
`define SEC_OP_RD_IDPAGE  8'h83
`define SEC_OP_WR_IDPAGE  8'h82

// ----------------------------------------
// Protected range starts
// ----------------------------------------
`define SEC_PROT_QUARTER  11'h600
`define SEC_PROT_HALF     11'h400
`define SEC_PROT_WHOLE    11'h000

// ----------------------------------------
// Address field layout
// ----------------------------------------
`define SEC_ADDR_MSB      10
`define SEC_ID_ADDR_MSB   4
`define SEC_LOCK_ADDR     16'h0400

// ----------------------------------------
// Status bit positions and reset values
// ----------------------------------------
`define SEC_ST_BUSY       0
`define SEC_ST_WEL        1
`define SEC_ST_BP_LO      2
`define SEC_ST_BP_HI      3
`define SEC_ST_SRWD       7
`define SEC_WEL_RST       1'b0

`endif

// ### hdl/sec_spi_eeprom_command_front.v
`timescale 1ns/1ps
`include "sec_defs.vh"

module sec_spi_eeprom_command_front #(
	parameter ID_PAGE_EN = 1
) (
	input  wire        i_core_clk,
	input  wire        i_sys_rst,
	input  wire        i_sclk,
	input  wire        i_cs_n,
	input  wire        i_mosi,
	input  wire        i_hold_n,
	input  wire        i_wp_n,
	input  wire        i_write_done,
	input  wire        i_srwd,
	input  wire        i_protect_bit_hi,
	input  wire        i_protect_bit_lo,
	output reg         o_miso_oe,
	output reg         o_busy_flag,
	output reg         o_write_enable_latch,
	output reg         o_mem_write_go,
	output reg         o_status_write_go,
	output reg         o_idpage_write_go,
	output reg         o_idpage_lock_go,
	output reg         o_read_go,
	output reg  [7:0]  o_opcode,
	output reg  [10:0] o_addr,
	output reg  [7:0]  o_data,
	output reg         o_data_valid,
	output reg         o_wait
);

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
reg [1:0] sclk_sync_reg;
reg [1:0] cs_sync_reg;
reg [1:0] mosi_sync_reg;
reg [1:0] hold_sync_reg;
reg [1:0] wp_sync_reg;
reg       sclk_d_reg;
reg       cs_d_reg;
reg       hold_d_reg;

always @(posedge i_core_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		sclk_sync_reg <= 2'h0;
		cs_sync_reg   <= 2'h3;
		mosi_sync_reg <= 2'h0;
		hold_sync_reg <= 2'h3;
		wp_sync_reg   <= 2'h3;
		sclk_d_reg    <= 1'b0;
		cs_d_reg      <= 1'b1;
		hold_d_reg    <= 1'b1;
	end else begin
		sclk_sync_reg <= {sclk_sync_reg[0], i_sclk};
		cs_sync_reg   <= {cs_sync_reg[0], i_cs_n};
		mosi_sync_reg <= {mosi_sync_reg[0], i_mosi};
		hold_sync_reg <= {hold_sync_reg[0], i_hold_n};
		wp_sync_reg   <= {wp_sync_reg[0], i_wp_n};
		sclk_d_reg    <= sclk_sync_reg[1];
		cs_d_reg      <= cs_sync_reg[1];
		hold_d_reg    <= hold_sync_reg[1];
	end
end

wire sclk_s  = sclk_sync_reg[1];
wire cs_s    = cs_sync_reg[1];
wire mosi_s  = mosi_sync_reg[1];
wire hold_s  = hold_sync_reg[1];
wire wp_s    = wp_sync_reg[1];
wire sclk_rise = sclk_s & ~sclk_d_reg;
wire sclk_fall = ~sclk_s & sclk_d_reg;
wire cs_fall   = ~cs_s & cs_d_reg;
wire cs_rise   = cs_s & ~cs_d_reg;

// ----------------------------------------
// Protocol states
// ----------------------------------------
localparam ST_IDLE = 3'h0;
localparam ST_OP   = 3'h1;
localparam ST_ADDR = 3'h2;
localparam ST_DATA = 3'h3;
localparam ST_WAIT = 3'h4;
localparam ST_READ = 3'h5;

reg [2:0]  state_reg;
reg [2:0]  bit_cnt_reg;
reg [7:0]  shift_reg;
reg [15:0] addr_reg;
reg        addr_byte_reg;
reg        armed_reg;
reg        selected_reg;
reg        paused_reg;
reg        byte_end_reg;
reg        data_seen_reg;
reg        write_ok_reg;

// Deselect in hold resets too; only a whole write survives it
wire opcode_done = sclk_rise & (bit_cnt_reg == 3'h7);

// Range
reg prot_hit;
always @* begin
	case ({i_protect_bit_hi, i_protect_bit_lo})
		2'h1:    prot_hit = addr_reg[10:0] >= `SEC_PROT_QUARTER;
		2'h2:    prot_hit = addr_reg[10:0] >= `SEC_PROT_HALF;
		2'h3:    prot_hit = addr_reg[10:0] >= `SEC_PROT_WHOLE;
		default: prot_hit = 1'b0;
	endcase
end

// Protect bits frozen when guard active
wire status_locked = i_srwd & ~wp_s;
wire active = selected_reg & ~paused_reg;

always @(posedge i_core_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		state_reg            <= ST_IDLE;
		bit_cnt_reg          <= 3'h0;
		shift_reg            <= 8'h00;
		addr_reg             <= 16'h0000;
		addr_byte_reg        <= 1'b0;
		armed_reg            <= 1'b0;
		selected_reg         <= 1'b0;
		paused_reg           <= 1'b0;
		byte_end_reg         <= 1'b0;
		data_seen_reg        <= 1'b0;
		write_ok_reg         <= 1'b0;
		o_miso_oe            <= 1'b0;
		o_busy_flag          <= 1'b0;
		o_write_enable_latch <= `SEC_WEL_RST;
		o_mem_write_go       <= 1'b0;
		o_status_write_go    <= 1'b0;
		o_idpage_write_go    <= 1'b0;
		o_idpage_lock_go     <= 1'b0;
		o_read_go            <= 1'b0;
		o_opcode             <= 8'h00;
		o_addr               <= 11'h000;
		o_data               <= 8'h00;
		o_data_valid         <= 1'b0;
		o_wait               <= 1'b0;
	end else begin
		o_mem_write_go    <= 1'b0;
		o_status_write_go <= 1'b0;
		o_idpage_write_go <= 1'b0;
		o_idpage_lock_go  <= 1'b0;
		o_read_go         <= 1'b0;
		o_data_valid      <= 1'b0;
		if (cs_s)
			armed_reg <= 1'b1;
		if (i_write_done)
			o_busy_flag <= 1'b0;
		if (i_write_done & o_busy_flag)
			o_write_enable_latch <= 1'b0;
		// Hold entry and exit only while clock low
		if (selected_reg & ~sclk_s & ~hold_s & hold_d_reg)
			paused_reg <= 1'b1;
		else if (paused_reg & ~sclk_s & hold_s)
			paused_reg <= 1'b0;
		if (cs_fall & armed_reg) begin
			selected_reg  <= 1'b1;
			state_reg     <= ST_OP;
			bit_cnt_reg   <= 3'h0;
			addr_byte_reg <= 1'b0;
			byte_end_reg  <= 1'b0;
			data_seen_reg <= 1'b0;
			paused_reg    <= 1'b0;
		end else if (cs_rise & selected_reg) begin
			// Execute only at byte boundary, whole bytes
			if (byte_end_reg & (bit_cnt_reg == 3'h0) & write_ok_reg) begin
				case (o_opcode)
					`SEC_OP_SET_WEL:   o_write_enable_latch <= 1'b1;
					`SEC_OP_CLR_WEL:   o_write_enable_latch <= 1'b0;
					`SEC_OP_WR_STATUS: begin
						if (data_seen_reg) begin
							o_status_write_go <= 1'b1;
							o_busy_flag       <= 1'b1;
						end
					end
					`SEC_OP_WR_MEM: begin
						if (data_seen_reg) begin
							o_mem_write_go <= 1'b1;
							o_busy_flag    <= 1'b1;
						end
					end
					`SEC_OP_WR_IDPAGE: begin
						if (data_seen_reg & addr_reg[`SEC_ADDR_MSB]) begin
							o_idpage_lock_go <= 1'b1;
							o_busy_flag      <= 1'b1;
						end else if (data_seen_reg) begin
							o_idpage_write_go <= 1'b1;
							o_busy_flag       <= 1'b1;
						end
					end
					default: o_wait <= 1'b0;
				endcase
			end
			selected_reg <= 1'b0;
			paused_reg   <= 1'b0;
			state_reg    <= ST_IDLE;
			o_wait       <= 1'b0;
			o_miso_oe    <= 1'b0;
		end else if (active) begin
			if (sclk_fall & (state_reg == ST_READ))
				o_miso_oe <= 1'b1;
			if (sclk_rise) begin
				// Any later edge spoils the boundary
				byte_end_reg <= (bit_cnt_reg == 3'h7);
				bit_cnt_reg  <= bit_cnt_reg + 3'h1;
				shift_reg    <= {shift_reg[6:0], mosi_s};
			end
			if (opcode_done) begin
				case (state_reg)
					ST_OP: begin
						o_opcode <= {shift_reg[6:0], mosi_s};
						write_ok_reg <= o_write_enable_latch;
						case ({shift_reg[6:0], mosi_s})
							`SEC_OP_SET_WEL,
							`SEC_OP_CLR_WEL: begin
								state_reg <= ST_WAIT;
								write_ok_reg <= 1'b1;
							end
							`SEC_OP_RD_STATUS: state_reg <= ST_READ;
							`SEC_OP_WR_STATUS: begin
								state_reg <= ST_DATA;
								if (status_locked)
									write_ok_reg <= 1'b0;
							end
							`SEC_OP_RD_MEM,
							`SEC_OP_WR_MEM: state_reg <= ST_ADDR;
							`SEC_OP_RD_IDPAGE,
							`SEC_OP_WR_IDPAGE: begin
								if (ID_PAGE_EN != 0)
									state_reg <= ST_ADDR;
								else begin
									state_reg <= ST_WAIT;
									o_wait    <= 1'b1;
								end
							end
							default: begin
								state_reg <= ST_WAIT;
								o_wait    <= 1'b1;
							end
						endcase
					end
					ST_ADDR: begin
						addr_reg      <= {addr_reg[7:0], shift_reg[6:0], mosi_s};
						addr_byte_reg <= 1'b1;
						if (addr_byte_reg) begin
							o_addr    <= addr_reg[2:0] == 3'h0 ?
								{3'h0, shift_reg[6:0], mosi_s} :
								{addr_reg[2:0], shift_reg[6:0], mosi_s};
							state_reg <= (o_opcode == `SEC_OP_RD_MEM ||
								o_opcode == `SEC_OP_RD_IDPAGE) ? ST_READ : ST_DATA;
							o_read_go <= (o_opcode == `SEC_OP_RD_MEM ||
								o_opcode == `SEC_OP_RD_IDPAGE);
						end
					end
					ST_DATA: begin
						o_data        <= {shift_reg[6:0], mosi_s};
						o_data_valid  <= write_ok_reg;
						data_seen_reg <= 1'b1;
						// Protected target refuses the whole write
						if (o_opcode == `SEC_OP_WR_MEM && prot_hit)
							write_ok_reg <= 1'b0;
						if (o_opcode == `SEC_OP_WR_IDPAGE &&
							addr_reg != `SEC_LOCK_ADDR &&
							addr_reg[15:`SEC_ID_ADDR_MSB+1] != 11'h000)
							write_ok_reg <= 1'b0;
					end
					default: o_wait <= o_wait;
				endcase
			end
		end else if (paused_reg)
			o_miso_oe <= 1'b0;
	end
end

endmodule

// ### bench/sec_master_model.sv
`timescale 1ns/1ps
module sec_master_model (
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_mosi,
	output logic o_hold_n
);
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
		o_hold_n = 1'b1;
	end
	// ----------------------------------------
	// Pause, entered and left at clock low
	// ----------------------------------------
	task automatic pause();
		int k;
		o_hold_n = 1'b0;
		for (k = 0; k < 3; k++) begin
			#100 o_sclk = 1'b1;
			o_mosi = ~o_mosi;
			#100 o_sclk = 1'b0;
		end
		#100 o_hold_n = 1'b1;
		#100;
	endtask
	// ----------------------------------------
	// One framed command, MSB first, clock idles low
	// ----------------------------------------
	task automatic cmd(input logic [31:0] v, input int n, input int hold_at);
		int i;
		o_cs_n = 1'b0;
		#100;
		for (i = n - 1; i >= 0; i--) begin
			o_mosi = v[i];
			#100 o_sclk = 1'b1;
			#100 o_sclk = 1'b0;
			if (i == hold_at) pause();
		end
		#50 o_cs_n = 1'b1;
		o_mosi = ~o_mosi;
		#600;
	endtask
	// ----------------------------------------
	// Frame cut by deselect while paused
	// ----------------------------------------
	task automatic cut(input logic [31:0] v, input int n);
		int i;
		o_cs_n = 1'b0;
		#100;
		for (i = n - 1; i >= 0; i--) begin
			o_mosi = v[i];
			#100 o_sclk = 1'b1;
			#100 o_sclk = 1'b0;
		end
		o_hold_n = 1'b0;
		#300 o_cs_n = 1'b1;
		#200 o_hold_n = 1'b1;
		#600;
	endtask
endmodule

// ### bench/sec_front_props.sv
`timescale 1ns/1ps
module sec_front_props (
	input wire        i_core_clk,
	input wire        i_sys_rst,
	input wire        i_cs_n,
	input wire        i_sclk,
	input wire        i_hold_n,
	input wire        i_wp_n,
	input wire        i_write_done,
	input wire        i_srwd,
	input wire        i_protect_bit_hi,
	input wire        i_protect_bit_lo,
	input wire        o_miso_oe,
	input wire        o_busy_flag,
	input wire        o_write_enable_latch,
	input wire        o_mem_write_go,
	input wire        o_status_write_go,
	input wire        o_read_go,
	input wire [10:0] o_addr,
	input wire        o_wait
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	property p_pause_float;
		(!i_hold_n && !i_sclk && !i_cs_n)[*6] |-> !o_miso_oe;
	endproperty
	a_pause_float: assert property (p_pause_float) else $error("oe in pause");
	property p_go_cs;
		o_mem_write_go |-> i_cs_n;
	endproperty
	a_go_cs: assert property (p_go_cs) else $error("go while selected");
	property p_wel;
		(o_mem_write_go || o_status_write_go) |-> o_write_enable_latch;
	endproperty
	a_wel: assert property (p_wel) else $error("go without latch");
	property p_busy_set;
		(o_mem_write_go || o_status_write_go) |=> o_busy_flag;
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("busy not set");
	property p_done;
		o_busy_flag && i_write_done |=> !o_busy_flag && !o_write_enable_latch;
	endproperty
	a_done: assert property (p_done) else $error("done not seen");
	property p_wait;
		o_wait |-> !o_mem_write_go && !o_read_go;
	endproperty
	a_wait: assert property (p_wait) else $error("go in wait");
	property p_prot;
		o_mem_write_go |-> !(i_protect_bit_hi && i_protect_bit_lo)
			&& !(i_protect_bit_hi && o_addr[10])
			&& !(i_protect_bit_lo && o_addr[10:9] == 2'b11);
	endproperty
	a_prot: assert property (p_prot) else $error("protected write");
	property p_hpm;
		o_status_write_go |-> !(i_srwd && !i_wp_n);
	endproperty
	a_hpm: assert property (p_hpm) else $error("status write locked");
endmodule
bind sec_spi_eeprom_command_front sec_front_props u_sec_front_props (
	.i_core_clk          (i_core_clk),
	.i_sys_rst           (i_sys_rst),
	.i_cs_n              (i_cs_n),
	.i_sclk              (i_sclk),
	.i_hold_n            (i_hold_n),
	.i_wp_n              (i_wp_n),
	.i_write_done        (i_write_done),
	.i_srwd              (i_srwd),
	.i_protect_bit_hi    (i_protect_bit_hi),
	.i_protect_bit_lo    (i_protect_bit_lo),
	.o_miso_oe           (o_miso_oe),
	.o_busy_flag         (o_busy_flag),
	.o_write_enable_latch(o_write_enable_latch),
	.o_mem_write_go      (o_mem_write_go),
	.o_status_write_go   (o_status_write_go),
	.o_read_go           (o_read_go),
	.o_addr              (o_addr),
	.o_wait              (o_wait)
);

// ### bench/sec_spi_eeprom_command_front_tb_top.sv
`timescale 1ns/1ps
module sec_spi_eeprom_command_front_tb_top;
	logic clk = 1'b0, rst = 1'b1, wp_n = 1'b1, done = 1'b0, srwd = 1'b0;
	logic bp_hi = 1'b0, bp_lo = 1'b0, sclk, cs_n, mosi, hold_n;
	logic oe, busy, write_enable_latch, mw, sw, iw, il, rd, dv, wt;
	logic [7:0] opc, dat, last_d;
	logic [10:0] addr;
	int n_errors = 0, num_checks = 0, cyc = 0, n_mw = 0, n_sw = 0, n_rd = 0;
	int n_wt = 0, n_iw = 0, n_il = 0, n_oe = 0;
	always #12.5 clk = ~clk;
	sec_master_model u_sec_master_model (.o_sclk(sclk), .o_cs_n(cs_n),
		.o_mosi(mosi), .o_hold_n(hold_n));
	sec_spi_eeprom_command_front u_sec_spi_eeprom_command_front (
		.i_core_clk(clk), .i_sys_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n),
		.i_mosi(mosi), .i_hold_n(hold_n), .i_wp_n(wp_n), .i_write_done(done),
		.i_srwd(srwd), .i_protect_bit_hi(bp_hi), .i_protect_bit_lo(bp_lo),
		.o_miso_oe(oe), .o_busy_flag(busy), .o_write_enable_latch(write_enable_latch),
		.o_mem_write_go(mw), .o_status_write_go(sw), .o_idpage_write_go(iw),
		.o_idpage_lock_go(il), .o_read_go(rd), .o_opcode(opc), .o_addr(addr),
		.o_data(dat), .o_data_valid(dv), .o_wait(wt));
	always @(posedge clk) begin
		cyc++;
		n_mw += (mw === 1'b1);
		n_sw += (sw === 1'b1);
		n_rd += (rd === 1'b1);
		n_wt += (wt === 1'b1);
		n_iw += (iw === 1'b1);
		n_il += (il === 1'b1);
		n_oe += (oe === 1'b1);
		if (dv === 1'b1) last_d <= dat;
		if (cyc > 20000) begin
			n_errors++;
			end_of_test();
		end
	end
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("wrong value %s exp %h got %h", nm, exp, got);
			n_errors++;
		end
	endtask
	task automatic c(logic [31:0] v, int n, int h = -1);
		@(posedge clk);
		#2;
		u_sec_master_model.cmd(v, n, h);
	endtask
	task automatic k(logic [31:0] v, int n);
		@(posedge clk);
		#2;
		u_sec_master_model.cut(v, n);
	endtask
	task automatic finish_write();
		@(posedge clk) #2 done = 1'b1;
		@(posedge clk) #2 done = 1'b0;
		repeat (3) @(posedge clk);
		#2;
		chk("busy", 0, busy);
		chk("latch", 0, write_enable_latch);
	endtask
	task automatic t_latch();
		c(32'h02_00_10_5A, 32);
		chk("mw_nolatch", 0, n_mw);
		c(8'h06, 8);
		chk("latch_set", 1, write_enable_latch);
		c(8'h04, 8);
		chk("latch_clr", 0, write_enable_latch);
	endtask
	task automatic t_write();
		c(8'h06, 8);
		c({8'h02, 16'hF812, 8'hA5}, 32);
		chk("mw", 1, n_mw);
		chk("addr", 11'h012, addr);
		chk("data", 8'hA5, last_d);
		chk("busy", 1, busy);
		finish_write();
	endtask
	task automatic t_bits();
		c(8'h06, 8);
		c({8'h02, 16'h0010, 7'h55}, 31);
		chk("mw_31", 1, n_mw);
	endtask
	task automatic t_prot();
		bp_lo = 1'b1;
		c({8'h02, 16'h0600, 8'h11}, 32);
		chk("mw_prot", 1, n_mw);
		c({8'h02, 16'h05FF, 8'h22}, 32);
		chk("mw_open", 2, n_mw);
		finish_write();
		bp_lo = 1'b0;
	endtask
	task automatic t_hold();
		c(8'h06, 8);
		c({8'h02, 16'h0123, 8'h3C}, 32, 20);
		chk("mw_hold", 3, n_mw);
		chk("addr_hold", 11'h123, addr);
		chk("data_hold", 8'h3C, last_d);
		finish_write();
	endtask
	task automatic t_hpm();
		srwd = 1'b1;
		wp_n = 1'b0;
		c(8'h06, 8);
		c({8'h01, 8'h8C}, 16);
		chk("sw_locked", 0, n_sw);
		wp_n = 1'b1;
		c({8'h01, 8'h8C}, 16);
		chk("sw", 1, n_sw);
		finish_write();
		srwd = 1'b0;
	endtask
	task automatic t_misc();
		int b;
		c({8'hFF, 8'h02}, 16);
		chk("wait_seen", 1, n_wt > 0);
		chk("wait_end", 0, wt);
		c({8'h03, 16'h0007}, 24);
		chk("rd", 1, n_rd);
		c({8'h83, 16'h0005}, 24);
		chk("rd_id", 2, n_rd);
		chk("opcode", 8'h83, opc);
		b = n_oe;
		c({8'h05, 8'h00}, 16);
		chk("oe_seen", 1, n_oe > b);
		chk("oe_off", 0, oe);
		c({8'h03, 16'h0007, 8'h00}, 32, 4);
		chk("rd_hold", 3, n_rd);
	endtask
	task automatic t_cut();
		c(8'h06, 8);
		k({8'h02, 12'h004}, 20);
		chk("mw_cut_part", 3, n_mw);
		chk("latch_kept", 1, write_enable_latch);
		k({8'h02, 16'h0041, 8'h66}, 32);
		chk("mw_cut_whole", 4, n_mw);
		chk("busy_cut", 1, busy);
		finish_write();
	endtask
	task automatic t_idp();
		c(8'h06, 8);
		c({8'h82, 16'h0025, 8'h11}, 32);
		chk("iw_badaddr", 0, n_iw);
		c({8'h82, 16'h0005, 8'h11}, 32);
		chk("iw", 1, n_iw);
		finish_write();
		c(8'h06, 8);
		c({8'h82, 16'h0400, 8'h02}, 32);
		chk("lock", 1, n_il);
		finish_write();
	endtask
	task automatic end_of_test();
		if (n_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		#2 rst = 1'b0;
		repeat (6) @(posedge clk);
		t_latch();
		t_write();
		t_bits();
		t_prot();
		t_hold();
		t_hpm();
		t_misc();
		t_cut();
		t_idp();
		end_of_test();
	end
endmodule
